// File: verilog/sfwl_pkg.sv
// Constants, opcodes and status layout of the flash command interpreter.
// Assumes a 20 MHz core clock that oversamples the serial pins.
// Contract
// - Opcode 06 sets the write latch
// - Opcodes take 8 single or 2 quad clocks
// - Opcode 04 clears the write latch
// - Latch clears at reset, suspend, command completion
// - Ident read shifts out 24 bits
// - Ident read not decoded while busy
// - Chip select high returns to standby
// - Status read accepted at any time
// - Status read drives status on output
// - Bit 0 is the busy flag
// - Bit 1 latch gates program, erase, write
// - Protected targets are never programmed or erased
// - Bits 5..2 protect level, default zero
// - Chip erase only with protect level zero
// - Bit 6 quad enable gates single quad commands
// - Quad enable ignored in quad command mode
// - Bit 7 lock with pin low blocks writes
// - Status write needs byte boundary, self-timed
// - Quad mode or quad enable disables lock
package sfwl_pkg;
    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_RD_STATE  = 8'h05;
    localparam logic [7:0] OP_RD_IDENT  = 8'h9F;
    localparam logic [7:0] OP_WR_STATE  = 8'h01;
    localparam logic [7:0] OP_PAGE_PGM  = 8'h02;
    localparam logic [7:0] OP_QUAD_PGM  = 8'h38;
    localparam logic [7:0] OP_SECT_ERS  = 8'h20;
    localparam logic [7:0] OP_HALF_ERS  = 8'h52;
    localparam logic [7:0] OP_BLK_ERS   = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERS  = 8'hC7;
    localparam logic [7:0] OP_QUAD_RD_A = 8'hEB;
    localparam logic [7:0] OP_QUAD_RD_B = 8'hE7;
    // ==========================================================
    // Status word field positions and reset values
    localparam int         ST_BUSY_BIT  = 0;
    localparam int         ST_LATCH_BIT = 1;
    localparam int         ST_PROT_LSB  = 2;
    localparam int         ST_QE_BIT    = 6;
    localparam int         ST_LOCK_BIT  = 7;
    localparam logic [3:0] PROT_RESET   = 4'h0;
    localparam logic       QE_RESET     = 1'b0;
    localparam logic       LOCK_RESET   = 1'b0;
    // Arbitrary identity value, not any real maker code
    localparam logic [23:0] IDENT_VALUE = 24'h5A0117;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int TW_NS         = 1000000;
    localparam int TW_CYCLES     = TW_NS / CLK_PERIOD_NS;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] TOO_LONG  = 4'hF;
    // ==========================================================
    // Phases of one chip-select frame
    typedef enum logic [2:0] {
        PH_IDLE, PH_OPC, PH_DONE, PH_WDATA, PH_DOUT
    } sfwl_phase_e;
endpackage

// File: verilog/sfwl_core.sv
// Serial flash command front end: latch, status and ident commands.
// Assumes the program/erase datapath sits outside and reports busy,
// completion and target protection on same-clock inputs.
`timescale 1ns/1ns
module sfwl_core #(
    parameter int TW_CYC = sfwl_pkg::TW_CYCLES  // Status write time
) (
    input  wire logic       I_MCLK,             // 20 MHz core clock
    input  wire logic       I_RESET_N,          // Sync reset, low
    input  wire logic       I_CS_N,             // Chip select pin
    input  wire logic       I_SCLK,             // Serial clock pin
    input  wire logic [3:0] I_SIO,              // I/O lines, in
    input  wire logic       I_QUAD_CMD_MODE,    // Quad command mode
    input  wire logic       I_PE_BUSY,          // Program/erase running
    input  wire logic       I_PE_DONE,          // Program/erase end
    input  wire logic       I_PE_SUSPEND,       // Program/erase suspend
    input  wire logic       I_TARGET_PROTECTED, // Target in prot area
    output logic      [3:0] O_SIO,              // I/O lines, out
    output logic      [3:0] O_SIO_OE,           // I/O line enables
    output logic      [7:0] O_STATUS,           // Live status word
    output logic            O_BUSY,             // Busy flag
    output logic            O_HW_LOCK_MODE,     // Hardware lock active
    output logic            O_CMD_STROBE,       // Accepted command
    output logic      [7:0] O_CMD_CODE          // Its opcode
);
    import sfwl_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0]  cs_sy;    // Chip select synchroniser
        logic [2:0]  sclk_sy;  // Serial clock synchroniser
        logic [3:0]  sio_sy0;  // I/O first stage
        logic [3:0]  sio_sy1;  // I/O second stage
        logic [3:0]  sio_sy2;  // I/O third stage
        logic        cs_f;     // Filtered chip select
        logic        sclk_f;   // Filtered serial clock
        logic [3:0]  sio_f;    // Filtered I/O
        sfwl_phase_e ph;       // Frame phase
        logic [7:0]  sh;       // Input shifter
        logic [3:0]  cnt;      // Input bit count
        logic [7:0]  opc;      // Decoded opcode
        logic [23:0] out;      // Output shifter
        logic [4:0]  ocnt;     // Output bits left
        logic        ident;    // Output is ident, not status
        logic        write_latch_flag;      // Write latch flag
        logic [3:0]  bp;       // Protect level bits
        logic        qe;       // Quad I/O enable
        logic        state_word_write_lock;     // Status write lock
        logic        wr_busy;  // Self-timed status write
        logic [31:0] twc;      // Write cycle counter
        logic [7:0]  wr_val;   // Pending status byte
        logic [3:0]  sio_o;    // Output data
        logic [3:0]  sio_oe;   // Output enables
        logic        strobe;   // Command strobe
        logic [7:0]  code;     // Command code
    } sfwl_state_s;

    sfwl_state_s s_ff;       // Registered state
    sfwl_state_s nxt_s;      // Next state

    // True for program and erase opcodes that need the latch
    function automatic logic is_pe(input logic [7:0] b);
        return b == OP_PAGE_PGM || b == OP_QUAD_PGM ||
               b == OP_SECT_ERS || b == OP_HALF_ERS ||
               b == OP_BLK_ERS || b == OP_CHIP_ERS;
    endfunction

    // True for quad commands issued in single-wire framing
    function automatic logic is_quad1(input logic [7:0] b);
        return b == OP_QUAD_RD_A || b == OP_QUAD_RD_B ||
               b == OP_QUAD_PGM;
    endfunction

    // ==========================================================
    // Edges and derived levels
    logic        cs_ok;      // Chip select stages agree
    logic        sclk_ok;    // Serial clock stages agree
    logic        cs_rise;    // Frame end
    logic        cs_fall;    // Frame start
    logic        sclk_rise;  // Input sample point
    logic        sclk_fall;  // Output change point
    logic        quad;       // Quad command mode
    logic        busy;       // Any write cycle running
    logic        hw_lock;    // Hardware lock mode
    logic [7:0]  status;     // Status word
    logic [3:0]  step;       // Bits per serial clock
    logic [7:0]  lanes;      // Shifter after this clock
    logic [3:0]  agree;      // Per-lane agreement
    logic        opc_done;   // Last opcode clock
    logic        wr_ok;      // Status write accepted

    assign cs_ok     = s_ff.cs_sy[1] == s_ff.cs_sy[2];
    assign sclk_ok   = s_ff.sclk_sy[1] == s_ff.sclk_sy[2];
    assign cs_rise   = cs_ok && s_ff.cs_sy[2] && !s_ff.cs_f;
    assign cs_fall   = cs_ok && !s_ff.cs_sy[2] && s_ff.cs_f;
    assign sclk_rise = sclk_ok && s_ff.sclk_sy[2] && !s_ff.sclk_f;
    assign sclk_fall = sclk_ok && !s_ff.sclk_sy[2] && s_ff.sclk_f;
    assign agree     = ~(s_ff.sio_sy1 ^ s_ff.sio_sy2);
    assign quad      = I_QUAD_CMD_MODE;
    assign busy      = s_ff.wr_busy | I_PE_BUSY;
    // Lock needs lock bit and pin low, and neither quad setting
    assign hw_lock   = s_ff.state_word_write_lock & ~s_ff.sio_f[2]
                     & ~s_ff.qe & ~quad;
    assign status    = {s_ff.state_word_write_lock, s_ff.qe, s_ff.bp, s_ff.write_latch_flag, busy};
    assign step      = quad ? 4'h4 : 4'h1;
    // Single-wire mode reads lane 0 only; upper lines are ignored
    assign lanes     = quad ? {s_ff.sh[3:0], s_ff.sio_f}
                            : {s_ff.sh[6:0], s_ff.sio_f[0]};
    assign opc_done  = !s_ff.cs_f && sclk_rise && s_ff.ph == PH_OPC &&
                       s_ff.cnt + step == BYTE_BITS;
    // Exactly one byte, latch set, idle and unlocked
    assign wr_ok     = cs_rise && s_ff.ph == PH_WDATA &&
                       s_ff.cnt == BYTE_BITS && s_ff.write_latch_flag && !busy &&
                       !hw_lock;

    // ==========================================================
    // Next-state logic
    always_comb begin
        nxt_s        = s_ff;
        nxt_s.strobe = 1'b0;
        // Three-stage pin synchronisers; a change counts on agreement
        nxt_s.cs_sy   = {s_ff.cs_sy[1:0], I_CS_N};
        nxt_s.sclk_sy = {s_ff.sclk_sy[1:0], I_SCLK};
        nxt_s.sio_sy0 = I_SIO;
        nxt_s.sio_sy1 = s_ff.sio_sy0;
        nxt_s.sio_sy2 = s_ff.sio_sy1;
        nxt_s.sio_f   = (agree & s_ff.sio_sy2) | (~agree & s_ff.sio_f);
        if (cs_ok) begin
            nxt_s.cs_f = s_ff.cs_sy[2];
        end
        if (sclk_ok) begin
            nxt_s.sclk_f = s_ff.sclk_sy[2];
        end
        // Self-timed status write; new bits land at the end
        if (s_ff.wr_busy) begin
            nxt_s.twc = s_ff.twc - 32'h1;
            if (s_ff.twc == 32'h1) begin
                nxt_s.wr_busy = 1'b0;
                nxt_s.write_latch_flag     = 1'b0;
                nxt_s.state_word_write_lock    = s_ff.wr_val[ST_LOCK_BIT];
                nxt_s.qe      = s_ff.wr_val[ST_QE_BIT];
                nxt_s.bp      = s_ff.wr_val[ST_PROT_LSB +: 4];
            end
        end
        // Datapath completion and suspend drop the latch
        if (I_PE_DONE || I_PE_SUSPEND) begin
            nxt_s.write_latch_flag = 1'b0;
        end
        if (cs_fall) begin
            // New frame: any earlier partial opcode is gone
            nxt_s.ph  = PH_OPC;
            nxt_s.cnt = 4'h0;
            nxt_s.sh  = 8'h00;
        end else if (cs_rise) begin
            // Frame end; commands take effect only on a full opcode
            if (s_ff.ph == PH_DONE && s_ff.opc == OP_CLR_LATCH) begin
                nxt_s.write_latch_flag = 1'b0;
            end
            // Set comes last so it wins over a same-cycle clear
            if (s_ff.ph == PH_DONE && s_ff.opc == OP_SET_LATCH &&
                !busy) begin
                nxt_s.write_latch_flag = 1'b1;
            end
            if (wr_ok) begin
                nxt_s.wr_busy = 1'b1;
                nxt_s.wr_val  = s_ff.sh;
                nxt_s.twc     = 32'(TW_CYC);
            end
            nxt_s.ph     = PH_IDLE;
            nxt_s.sio_oe = 4'h0;
        end else if (!s_ff.cs_f && sclk_rise) begin
            if (s_ff.ph == PH_OPC) begin
                nxt_s.sh  = lanes;
                nxt_s.cnt = s_ff.cnt + step;
                if (opc_done) begin
                    nxt_s.opc = lanes;
                    nxt_s.ph  = PH_DONE;
                    if (lanes == OP_RD_STATE) begin
                        // Allowed even while busy
                        nxt_s.ph    = PH_DOUT;
                        nxt_s.out   = {status, 16'h0000};
                        nxt_s.ocnt  = 5'h08;
                        nxt_s.ident = 1'b0;
                    end else if (lanes == OP_RD_IDENT) begin
                        if (!busy && !quad) begin
                            nxt_s.ph    = PH_DOUT;
                            nxt_s.out   = IDENT_VALUE;
                            nxt_s.ocnt  = 5'h18;
                            nxt_s.ident = 1'b1;
                        end
                    end else if (lanes == OP_WR_STATE) begin
                        nxt_s.ph  = PH_WDATA;
                        nxt_s.cnt = 4'h0;
                    end else if (is_pe(lanes)) begin
                        // Latch, idle, protection and quad gating
                        if (s_ff.write_latch_flag && !busy &&
                            !I_TARGET_PROTECTED &&
                            !(lanes == OP_CHIP_ERS &&
                              s_ff.bp != PROT_RESET) &&
                            (quad || s_ff.qe ||
                             !is_quad1(lanes))) begin
                            nxt_s.strobe = 1'b1;
                            nxt_s.code   = lanes;
                        end
                    end else if (lanes != OP_SET_LATCH &&
                                 lanes != OP_CLR_LATCH) begin
                        // Other commands go on to the datapath
                        if (!busy && (quad || s_ff.qe ||
                                      !is_quad1(lanes))) begin
                            nxt_s.strobe = 1'b1;
                            nxt_s.code   = lanes;
                        end
                    end
                end
            end else if (s_ff.ph == PH_WDATA) begin
                // Extra clocks past the byte mark the write as bad
                if (s_ff.cnt < BYTE_BITS) begin
                    nxt_s.sh  = lanes;
                    nxt_s.cnt = s_ff.cnt + step;
                end else begin
                    nxt_s.cnt = TOO_LONG;
                end
            end
        end else if (!s_ff.cs_f && sclk_fall && s_ff.ph == PH_DOUT) begin
            // Output changes on falling clock, sampled on rising
            if (quad) begin
                nxt_s.sio_o  = s_ff.out[23:20];
                nxt_s.sio_oe = 4'hF;
                nxt_s.out    = {s_ff.out[19:0], 4'h0};
            end else begin
                nxt_s.sio_o  = {2'b00, s_ff.out[23], 1'b0};
                nxt_s.sio_oe = 4'h2;
                nxt_s.out    = {s_ff.out[22:0], 1'b0};
            end
            nxt_s.ocnt = s_ff.ocnt - {1'b0, step};
            // Status repeats with live contents until the frame ends
            if (s_ff.ocnt <= {1'b0, step} && !s_ff.ident) begin
                nxt_s.out  = {status, 16'h0000};
                nxt_s.ocnt = 5'h08;
            end
        end
    end

    // ==========================================================
    // State register; protect, quad and lock reset to defaults
    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            s_ff         <= '0;
            s_ff.cs_sy   <= 3'h7;
            s_ff.cs_f    <= 1'b1;
            s_ff.ph      <= PH_IDLE;
            s_ff.write_latch_flag     <= 1'b0;
            s_ff.bp      <= PROT_RESET;
            s_ff.qe      <= QE_RESET;
            s_ff.state_word_write_lock    <= LOCK_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign O_SIO          = s_ff.sio_o;
    assign O_SIO_OE       = s_ff.sio_oe;
    assign O_STATUS       = status;
    assign O_BUSY         = busy;
    assign O_HW_LOCK_MODE = hw_lock;
    assign O_CMD_STROBE   = s_ff.strobe;
    assign O_CMD_CODE     = s_ff.code;

    // ==========================================================
    // Checks
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);

    property p_wel_set;
        cs_rise && s_ff.ph == PH_DONE && s_ff.opc == OP_SET_LATCH &&
        !busy |=> s_ff.write_latch_flag;
    endproperty
    a_wel_set: assert property (p_wel_set)
        else $error("latch not set");
    property p_wel_clr;
        cs_rise && s_ff.ph == PH_DONE && s_ff.opc == OP_CLR_LATCH
        |=> !s_ff.write_latch_flag;
    endproperty
    a_wel_clr: assert property (p_wel_clr)
        else $error("latch not cleared");
    property p_wel_pe;
        (I_PE_DONE || I_PE_SUSPEND) && !cs_rise |=> !s_ff.write_latch_flag;
    endproperty
    a_wel_pe: assert property (p_wel_pe)
        else $error("latch kept after program end");
    property p_busy_hold;
        wr_ok |=> O_BUSY[*4] ##1 (O_BUSY && s_ff.write_latch_flag);
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("status write cycle too short");
    property p_chip_erase;
        s_ff.strobe && s_ff.code == OP_CHIP_ERS |->
        $past(s_ff.bp) == PROT_RESET && $past(s_ff.write_latch_flag);
    endproperty
    a_chip_erase: assert property (p_chip_erase)
        else $error("chip erase while protected");
    property p_lock;
        $rose(s_ff.wr_busy) |-> $past(!hw_lock && s_ff.write_latch_flag);
    endproperty
    a_lock: assert property (p_lock)
        else $error("status write under lock");
    property p_ident;
        s_ff.ph == PH_DOUT && s_ff.ident && $past(s_ff.ph) == PH_OPC
        |-> !$past(busy);
    endproperty
    a_ident: assert property (p_ident)
        else $error("ident decoded while busy");
    property p_stby;
        cs_rise |=> s_ff.ph == PH_IDLE && O_SIO_OE == 4'h0;
    endproperty
    a_stby: assert property (p_stby)
        else $error("no standby after frame");
    property p_bp;
        $changed(s_ff.bp) |-> $past(s_ff.wr_busy && s_ff.twc == 32'h1);
    endproperty
    a_bp: assert property (p_bp)
        else $error("protect bits changed outside write");
    property p_read_state_word_cmd;
        opc_done && lanes == OP_RD_STATE |=> s_ff.ph == PH_DOUT &&
        s_ff.out[23:16] == $past(status);
    endproperty
    a_read_state_word_cmd: assert property (p_read_state_word_cmd)
        else $error("status read not started");
endmodule

// File: verification/sfwl_host_model.sv
// Host controller model: frames opcodes and data, then reads answers.
// Assumes the bench resolves shared I/O lanes before feeding them back.
`timescale 1ns/1ns
module sfwl_host_model (
    input  wire logic        i_mclk,     // Core clock, paces the link
    input  wire logic        i_wp,       // Protect pin level to present
    input  wire logic [3:0]  i_sio,      // Resolved I/O lane levels
    input  wire logic [3:0]  i_sio_oe,   // Device lane enables
    output logic             o_cs_n,     // Chip select, low active
    output logic             o_sclk,     // Link clock, still outside frames
    output logic      [3:0]  o_sio,      // Host lane values
    output logic             o_rd_valid, // One-cycle read result pulse
    output logic      [24:0] o_rd_data   // {all bits driven, read bits}
);
    int seed = 51556;                    // Noise for lanes the device ignores
    // ==========================================================
    // Idle levels
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sio = 4'h5;
        o_rd_valid = 1'b0;
        o_rd_data = 25'h0;
    end
    // Released lanes flip, so a stale value can never pass for an answer
    function automatic logic [3:0] idle_lanes(input bit quad);
        return quad ? ~o_sio : {~o_sio[3], i_wp, ~o_sio[1:0]};
    endfunction
    // ==========================================================
    // One frame: nwr bits out, nrd bits in, SCLK 5 MCLK low, 4 high
    task automatic frame(input bit quad, input logic [15:0] wr,
                         input int nwr, input int nrd);
        int          st;
        logic [3:0]  lanes;
        logic [24:0] rd;
        st = quad ? 4 : 1;
        rd = 25'h1000000;
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        for (int i = 0; i < nwr + nrd; i += st) begin
            @(posedge i_mclk);
            lanes = 4'($random(seed));
            if (i >= nwr) o_sio <= idle_lanes(quad);
            else if (quad) o_sio <= wr[15-i -: 4];
            else o_sio <= {lanes[3], i_wp, lanes[1], wr[15-i]};
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_mclk);
            // Sample at the end of the high phase, where output stands
            if (i >= nwr && quad)
                rd = {rd[24] & (&i_sio_oe), rd[19:0], i_sio & i_sio_oe};
            else if (i >= nwr)
                rd = {rd[24] & i_sio_oe[1], rd[22:0], i_sio[1] & i_sio_oe[1]};
            o_sclk <= 1'b0;
        end
        @(posedge i_mclk);
        o_cs_n <= 1'b1;
        o_sio <= idle_lanes(quad);
        if (nrd > 0) begin
            o_rd_data <= rd;
            o_rd_valid <= 1'b1;
        end
        @(posedge i_mclk);
        o_rd_valid <= 1'b0;
        repeat (7) @(posedge i_mclk);
    endtask
    // Between frames: show the current protect pin level on lane 2,
    // since the lanes otherwise keep what the last frame left there
    task automatic park;
        @(posedge i_mclk);
        o_sio <= idle_lanes(1'b0);
    endtask
endmodule

// File: verification/test_serial_flash_write_latch_status.sv
// Self-checking bench for the flash command front end.
// Assumes sfwl_pkg, sfwl_core and the host model are compiled first.
`timescale 1ns/1ns
module test_serial_flash_write_latch_status;
    import sfwl_pkg::*;
    localparam int TW = 20;                  // Short status write time
    logic        mclk = 1'b0;                // 50 ns core clock
    logic        rst_n = 1'b0;               // Sync reset, low
    logic        quad = 1'b0;                // Quad command mode
    logic        pe_busy = 1'b0;             // Datapath running
    logic        pe_done = 1'b0;             // Datapath completion
    logic        pe_susp = 1'b0;             // Datapath suspend
    logic        tprot = 1'b0;               // Target protected
    logic        wp = 1'b1;                  // Protect pin level
    logic        cs_n, sclk, busy, hwl, strobe, rdv;
    logic [3:0]  hsio, pin, dsio, oe;
    logic [7:0]  status, code, d;
    logic [24:0] rdd;
    logic [24:0] exp_q[$];                   // Expected read results
    logic [7:0]  cmd_q[$];                   // Expected accepted opcodes
    logic [7:0]  pgm[5] = '{OP_PAGE_PGM, OP_SECT_ERS, OP_HALF_ERS,
                            OP_BLK_ERS, OP_CHIP_ERS};
    int          fail_count = 0;
    int          checks = 0;
    int          seed = 51556;
    // Device drives a lane where enabled, the host elsewhere
    assign pin = (oe & dsio) | (~oe & hsio);
    initial forever #25 mclk = ~mclk;
    sfwl_core #(.TW_CYC(TW)) i_sfwl_core (
        .I_MCLK(mclk), .I_RESET_N(rst_n), .I_CS_N(cs_n), .I_SCLK(sclk),
        .I_SIO(pin), .I_QUAD_CMD_MODE(quad), .I_PE_BUSY(pe_busy),
        .I_PE_DONE(pe_done), .I_PE_SUSPEND(pe_susp),
        .I_TARGET_PROTECTED(tprot), .O_SIO(dsio), .O_SIO_OE(oe),
        .O_STATUS(status), .O_BUSY(busy), .O_HW_LOCK_MODE(hwl),
        .O_CMD_STROBE(strobe), .O_CMD_CODE(code));
    sfwl_host_model i_sfwl_host_model (
        .i_mclk(mclk), .i_wp(wp), .i_sio(pin), .i_sio_oe(oe),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_sio(hsio),
        .o_rd_valid(rdv), .o_rd_data(rdd));
    // ==========================================================
    // Checking and closing
    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (exp_q.size() != 0 || cmd_q.size() != 0) fail_count++;
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Note the expectation first, then run the frame
    task automatic op(input bit q, input logic [15:0] w, input int nw,
                      input int nr, input logic [24:0] e);
        if (nr > 0) exp_q.push_back(e);
        i_sfwl_host_model.frame(q, w, nw, nr);
    endtask
    // Status read of two bytes: the value repeats
    task automatic sr(input logic [7:0] s);
        op(0, {OP_RD_STATE, 8'h00}, 8, 16, {9'h100, s, s});
    endtask
    // Bounded poll of busy, as a careful host does
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < TW + 10) begin
            @(posedge mclk);
            n++;
        end
        check({24'h0, n < TW + 10}, 25'h1);
    endtask
    // Monitor: results pop the oldest note; only program/erase codes
    always @(posedge mclk) begin
        if (rdv) check(rdd, exp_q.size() > 0 ? exp_q.pop_front() : '1);
        if (strobe && code inside {pgm, OP_QUAD_PGM})
            check({17'h0, code}, cmd_q.size() > 0 ? cmd_q.pop_front() : '1);
    end
    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        close_out();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        sr(8'h00);
        op(0, 16'h0600, 8, 0, 0);
        sr(8'h02);
        op(0, 16'h0400, 8, 0, 0);
        sr(8'h00);
        op(0, 16'h0600, 4, 0, 0);
        sr(8'h00);
        quad <= 1'b1;
        op(1, 16'h0600, 8, 0, 0);
        op(1, 16'h0500, 8, 16, {9'h100, 16'h0202});
        quad <= 1'b0;
        op(0, 16'h0400, 8, 0, 0);
        op(0, 16'h9F00, 8, 24, {1'b1, IDENT_VALUE});
        op(0, 16'h9F00, 8, 8, {17'h10000, IDENT_VALUE[23:16]});
        pe_busy <= 1'b1;
        op(0, 16'h9F00, 8, 24, 25'h0);
        op(0, 16'h0600, 8, 0, 0);
        sr(8'h01);
        pe_busy <= 1'b0;
        sr(8'h00);
        foreach (pgm[k]) begin
            op(0, 16'h0600, 8, 0, 0);
            cmd_q.push_back(pgm[k]);
            op(0, {pgm[k], 8'h00}, 8, 0, 0);
            sr(8'h02);
            pe_done <= 1'b1;
            @(posedge mclk);
            pe_done <= 1'b0;
            sr(8'h00);
        end
        op(0, {OP_PAGE_PGM, 8'h00}, 8, 0, 0);
        op(0, 16'h0600, 8, 0, 0);
        tprot <= 1'b1;
        op(0, {OP_SECT_ERS, 8'h00}, 8, 0, 0);
        tprot <= 1'b0;
        op(0, {OP_QUAD_PGM, 8'h00}, 8, 0, 0);
        pe_susp <= 1'b1;
        @(posedge mclk);
        pe_susp <= 1'b0;
        sr(8'h00);
        d = {2'b00, 4'($random(seed)) | 4'h1, 2'b00};
        op(0, 16'h0600, 8, 0, 0);
        op(0, {OP_WR_STATE, d}, 16, 0, 0);
        check({24'h0, busy}, 25'h1);
        wait_idle();
        sr(d);
        check({17'h0, status}, {17'h0, d});
        op(0, 16'h0600, 8, 0, 0);
        op(0, {OP_CHIP_ERS, 8'h00}, 8, 0, 0);
        op(0, 16'h0600, 8, 0, 0);
        op(0, {OP_WR_STATE, 8'h80}, 16, 0, 0);
        wait_idle();
        sr(8'h80);
        wp <= 1'b0;
        i_sfwl_host_model.park();
        repeat (6) @(posedge mclk);
        check({24'h0, hwl}, 25'h1);
        quad <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        check({24'h0, hwl}, 25'h0);
        quad <= 1'b0;
        op(0, 16'h0600, 8, 0, 0);
        op(0, {OP_WR_STATE, 8'h00}, 16, 0, 0);
        sr(8'h82);
        wp <= 1'b1;
        op(0, {OP_WR_STATE, 8'h00}, 12, 0, 0);
        sr(8'h82);
        op(0, {OP_WR_STATE, 8'h00}, 16, 0, 0);
        wait_idle();
        sr(8'h00);
        close_out();
    end
endmodule
